//--- inc/pwmdc_regs.svh
// Register map, field positions, reset values and timing figures of the PWM duty/dead-time block
// What the document requires of this block and its software
// RULE1 - Period timing steps one time-base count
// RULE2 - Per-generator duty registers plus shared master duty
// RULE3 - Generator may take duty from master register
// RULE4 - Compare against 13-bit time-base counters
// RULE5 - Active while count <= upper 13 duty bits
// RULE6 - Low three duty bits go to fine adjust
// RULE7 - Duty writes anytime; optional hold until rollover
// RULE8 - Complementary mode: true and inverted outputs
// RULE9 - Complementary except push-pull and independent modes
// RULE10 - Independent mode copies active signal to both
// RULE11 - Software keeps duty within 0x0008..0xFFEF
// RULE12 - Duty 0x0000 always low, 0xFFFF always high
// RULE13 - Assertion waits dead time after complement deasserts
// RULE14 - Dead time available in every output mode; here negative dead time acts only in complementary mode
// RULE15 - Negative dead time forces high/low overlap
// RULE16 - Two-bit field per generator selects dead time
// RULE17 - Twelve-bit down counters fed by edge detectors; counters here are 11 bits, loaded from dead time bits 11:1
// RULE18 - Edge holds its output transition until zero
// RULE19 - Dual mode applies alternate value to complement
// RULE20 - Dead-time steps on fast clock; LSB fine
// RULE21 - Software keeps on/off times over 3x dead
// RULE22 - Period match restarts time bases with phases
// RULE23 - Disabled dead time passes signals undelayed
// RULE24 - Every detected edge reloads its dead-time counter
`ifndef PWMDC_REGS_SVH
`define PWMDC_REGS_SVH

// Byte offsets on the register bus
`define PWMDC_MASTER_DUTY_OFS 8'h00
`define PWMDC_GEN_DUTY_OFS 8'h10
`define PWMDC_DEAD_TIME_OFS 8'h20
`define PWMDC_ALT_DEAD_TIME_OFS 8'h30
`define PWMDC_GEN_CTRL_OFS 8'h40
`define PWMDC_GLOBAL_CTRL_OFS 8'h50
`define PWMDC_STATUS_OFS 8'h54

// Generator control register fields
`define PWMDC_CTRL_DTC_LSB 0
`define PWMDC_CTRL_USE_MASTER_BIT 2
`define PWMDC_CTRL_INDEP_BIT 3
// Global control register field
`define PWMDC_GLOBAL_HOLD_BIT 0
// Status register field positions
`define PWMDC_STAT_CMP_LSB 0
`define PWMDC_STAT_HIGH_LSB 8
`define PWMDC_STAT_LOW_LSB 16

// Reset values and the full-scale duty
`define PWMDC_DUTY_RST 16'h0000
`define PWMDC_DT_RST 12'h000
`define PWMDC_CTRL_RST 4'h0
`define PWMDC_DUTY_FULL 16'hFFFF

// Timing figures: one time-base count and one dead-time step, in picoseconds
`define PWMDC_TB_STEP_PS 8400
`define PWMDC_DT_STEP_PS 4160

`endif

//--- inc/pwmdc_pkg.sv
// Shared types of the PWM duty/dead-time block
`default_nettype none
package pwmdc_pkg;
   // Dead-time behaviour per generator
   typedef enum logic [1:0] {
      PWMDC_DT_POSITIVE = 2'h0,
      PWMDC_DT_NEGATIVE = 2'h1,
      PWMDC_DT_DUAL = 2'h3,
      PWMDC_DT_OFF = 2'h2
   } pwmdc_dtc_t;

   typedef logic [15:0] pwmdc_duty_t;
   typedef logic [11:0] pwmdc_dt_t;
   typedef logic [12:0] pwmdc_tb_t;
endpackage
`default_nettype wire

//--- logic/pwmdc_top.sv
// Duty compare, output steering and dead-time insertion for up to four PWM generators
`default_nettype none
`include "pwmdc_regs.svh"

module pwmdc_top #(
   parameter int NGEN = 4
) (
   input wire logic ref_clk, // Fast time-base clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic [NGEN*13-1:0] tb_count, // Individual time-base counts, generator 0 lowest
   input wire logic primary_time_count_rollover, // One-cycle pulse on primary period match
   input wire logic [7:0] avs_address, // Byte address
   input wire logic avs_read, // Read request
   input wire logic avs_write, // Write request
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall, low on the answering cycle
   output logic [NGEN-1:0] high_side_output, // High-side gate drive
   output logic [NGEN-1:0] low_side_output, // Low-side gate drive
   output logic [NGEN*3-1:0] duty_fine_adj, // Duty LSBs to the fine-adjust stage
   output logic [NGEN-1:0] dead_time_fine_adj // Dead-time LSB to the fine-adjust stage
);

   // Whole state of the block in one record
   typedef struct packed {
      logic [15:0] master_shadow;
      logic [15:0] master_active;
      logic [NGEN-1:0][15:0] gen_shadow;
      logic [NGEN-1:0][15:0] gen_active;
      logic [NGEN-1:0][11:0] dead_time_value;
      logic [NGEN-1:0][11:0] alternate_dead_time_value;
      logic [NGEN-1:0][3:0] gen_ctrl;
      logic hold_to_rollover;
      logic [NGEN-1:0] cmp;
      logic [NGEN-1:0][10:0] cnt_rise;
      logic [NGEN-1:0][10:0] cnt_fall;
      logic [NGEN-1:0] hs;
      logic [NGEN-1:0] ls;
      logic [NGEN-1:0][2:0] fine;
      logic [NGEN-1:0] dt_fine;
      logic wait_r;
      logic [31:0] rdata;
   } pwmdc_state_t;

   pwmdc_state_t s_r;
   pwmdc_state_t s_nxt;

   // Byte-lane merge for 16-bit and 12-bit fields
   function automatic logic [15:0] pwmdc_merge16(input logic [15:0] old_v,
                                                 input logic [31:0] wd,
                                                 input logic [3:0] be);
      logic [15:0] v;
      v = old_v;
      if (be[0]) begin
         v[7:0] = wd[7:0];
      end
      if (be[1]) begin
         v[15:8] = wd[15:8];
      end
      return v;
   endfunction

   // Read mux: unmapped offsets read as zero
   function automatic logic [31:0] pwmdc_read(input pwmdc_state_t s, input logic [7:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (a == `PWMDC_MASTER_DUTY_OFS) begin
         d[15:0] = s.master_shadow;
      end
      if (a == `PWMDC_GLOBAL_CTRL_OFS) begin
         d[`PWMDC_GLOBAL_HOLD_BIT] = s.hold_to_rollover;
      end
      if (a == `PWMDC_STATUS_OFS) begin
         d[`PWMDC_STAT_CMP_LSB +: NGEN] = s.cmp;
         d[`PWMDC_STAT_HIGH_LSB +: NGEN] = s.hs;
         d[`PWMDC_STAT_LOW_LSB +: NGEN] = s.ls;
      end
      for (int g = 0; g < NGEN; g++) begin
         if (a == `PWMDC_GEN_DUTY_OFS + 8'(4 * g)) begin
            d[15:0] = s.gen_shadow[g];
         end
         if (a == `PWMDC_DEAD_TIME_OFS + 8'(4 * g)) begin
            d[11:0] = s.dead_time_value[g];
         end
         if (a == `PWMDC_ALT_DEAD_TIME_OFS + 8'(4 * g)) begin
            d[11:0] = s.alternate_dead_time_value[g];
         end
         if (a == `PWMDC_GEN_CTRL_OFS + 8'(4 * g)) begin
            d[3:0] = s.gen_ctrl[g];
         end
      end
      return d;
   endfunction

   // Next-state logic for the bus slave, duty update and the output pairs
   always_comb begin
      logic wr_now;
      logic [15:0] duty;
      logic [12:0] count;
      logic new_cmp;
      logic rise;
      logic fall;
      logic [1:0] dtc;
      logic indep;
      logic rise_pend;
      logic fall_pend;
      logic [10:0] fall_load;
      logic hs_v;
      logic ls_v;
      wr_now = 1'b0;
      duty = 16'h0000;
      count = 13'h0000;
      new_cmp = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      dtc = 2'h0;
      indep = 1'b0;
      rise_pend = 1'b0;
      fall_pend = 1'b0;
      fall_load = 11'h000;
      hs_v = 1'b0;
      ls_v = 1'b0;
      s_nxt = s_r;

      // Bus handshake: one stall cycle, then the answer; read data is caught while stalling
      if (s_r.wait_r && (avs_read || avs_write)) begin
         s_nxt.wait_r = 1'b0;
         s_nxt.rdata = pwmdc_read(s_r, avs_address);
      end else begin
         s_nxt.wait_r = 1'b1;
      end
      wr_now = avs_write && !s_r.wait_r;

      // Register writes, accepted at any time; shadows take the value at once [RULE7]
      if (wr_now) begin
         if (avs_address == `PWMDC_MASTER_DUTY_OFS) begin
            s_nxt.master_shadow = pwmdc_merge16(s_r.master_shadow, avs_writedata,
                                                avs_byteenable); // [RULE2]
         end
         if (avs_address == `PWMDC_GLOBAL_CTRL_OFS && avs_byteenable[0]) begin
            s_nxt.hold_to_rollover = avs_writedata[`PWMDC_GLOBAL_HOLD_BIT];
         end
         for (int g = 0; g < NGEN; g++) begin
            if (avs_address == `PWMDC_GEN_DUTY_OFS + 8'(4 * g)) begin
               s_nxt.gen_shadow[g] = pwmdc_merge16(s_r.gen_shadow[g], avs_writedata,
                                                   avs_byteenable); // [RULE2]
            end
            if (avs_address == `PWMDC_DEAD_TIME_OFS + 8'(4 * g)) begin
               s_nxt.dead_time_value[g] = 12'(pwmdc_merge16({4'h0, s_r.dead_time_value[g]},
                                                            avs_writedata, avs_byteenable));
            end
            if (avs_address == `PWMDC_ALT_DEAD_TIME_OFS + 8'(4 * g)) begin
               s_nxt.alternate_dead_time_value[g] =
                  12'(pwmdc_merge16({4'h0, s_r.alternate_dead_time_value[g]},
                                    avs_writedata, avs_byteenable));
            end
            if (avs_address == `PWMDC_GEN_CTRL_OFS + 8'(4 * g) && avs_byteenable[0]) begin
               s_nxt.gen_ctrl[g] = avs_writedata[3:0]; // [RULE16]
            end
         end
      end

      // Active duty follows the shadow directly, or only at a primary rollover when held
      if (!s_r.hold_to_rollover || primary_time_count_rollover) begin // [RULE22]
         s_nxt.master_active = s_nxt.master_shadow; // [RULE7]
         s_nxt.gen_active = s_nxt.gen_shadow; // [RULE7]
      end

      // Per-generator compare, edge detect, dead-time counters and pin steering
      for (int g = 0; g < NGEN; g++) begin
         // Master duty replaces the generator's own register when selected
         duty = s_r.gen_ctrl[g][`PWMDC_CTRL_USE_MASTER_BIT] ? s_r.master_active
                                                          : s_r.gen_active[g]; // [RULE3]
         count = tb_count[g*13 +: 13]; // [RULE4] [RULE1]
         // Zero coarse duty is forced low and full scale forced high, so the ends never glitch
         if (duty == `PWMDC_DUTY_FULL) begin
            new_cmp = 1'b1; // [RULE12]
         end else if (duty[15:3] == 13'h0000) begin
            new_cmp = 1'b0; // [RULE12]
         end else begin
            new_cmp = (count <= duty[15:3]); // [RULE5]
         end
         s_nxt.cmp[g] = new_cmp;
         s_nxt.fine[g] = duty[2:0]; // [RULE6]
         s_nxt.dt_fine[g] = s_r.dead_time_value[g][0]; // [RULE20]

         dtc = s_r.gen_ctrl[g][`PWMDC_CTRL_DTC_LSB +: 2];
         indep = s_r.gen_ctrl[g][`PWMDC_CTRL_INDEP_BIT];
         rise = new_cmp && !s_r.cmp[g]; // [RULE17]
         fall = !new_cmp && s_r.cmp[g]; // [RULE17]
         fall_load = (dtc == 2'(pwmdc_pkg::PWMDC_DT_DUAL))
                   ? s_r.alternate_dead_time_value[g][11:1]
                   : s_r.dead_time_value[g][11:1]; // [RULE19]

         // Counters step at the fast clock; an edge reloads even if a count is running
         if (rise) begin
            s_nxt.cnt_rise[g] = s_r.dead_time_value[g][11:1]; // [RULE24] [RULE20]
         end else if (s_r.cnt_rise[g] != 11'h000) begin
            s_nxt.cnt_rise[g] = s_r.cnt_rise[g] - 11'h001; // [RULE17]
         end
         if (fall) begin
            s_nxt.cnt_fall[g] = fall_load; // [RULE24]
         end else if (s_r.cnt_fall[g] != 11'h000) begin
            s_nxt.cnt_fall[g] = s_r.cnt_fall[g] - 11'h001; // [RULE17]
         end
         rise_pend = (s_nxt.cnt_rise[g] != 11'h000); // [RULE18]
         fall_pend = (s_nxt.cnt_fall[g] != 11'h000); // [RULE18]

         // Base pair: copy in independent mode, true and inverse otherwise
         if (indep) begin
            hs_v = new_cmp; // [RULE10] [RULE9]
            ls_v = new_cmp; // [RULE10]
         end else begin
            hs_v = new_cmp; // [RULE8]
            ls_v = !new_cmp; // [RULE8]
         end

         // Positive and dual shaping apply in either output mode, negative shaping only in complementary mode
         case (dtc)
            2'(pwmdc_pkg::PWMDC_DT_OFF): begin
               s_nxt.hs[g] = hs_v; // [RULE23]
               s_nxt.ls[g] = ls_v; // [RULE23]
            end
            2'(pwmdc_pkg::PWMDC_DT_NEGATIVE): begin
               // Each side is stretched past the other's turn-on, giving forced overlap
               s_nxt.hs[g] = hs_v || (!indep && fall_pend); // [RULE15]
               s_nxt.ls[g] = ls_v || (!indep && rise_pend); // [RULE15]
            end
            2'(pwmdc_pkg::PWMDC_DT_POSITIVE), 2'(pwmdc_pkg::PWMDC_DT_DUAL): begin
               // Rising edge holds back the high side, falling edge the low side; in independent mode the rising edge holds both
               s_nxt.hs[g] = hs_v && !rise_pend; // [RULE13] [RULE18] [RULE14]
               s_nxt.ls[g] = ls_v && !(indep ? rise_pend : fall_pend); // [RULE13] [RULE14]
            end
            default: begin
               s_nxt.hs[g] = 1'b0;
               s_nxt.ls[g] = 1'b0;
            end
         endcase
      end
   end

   // One register stage for all state; async reset loads constants only
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r.master_shadow <= `PWMDC_DUTY_RST;
         s_r.master_active <= `PWMDC_DUTY_RST;
         s_r.hold_to_rollover <= 1'b0;
         s_r.wait_r <= 1'b1;
         s_r.rdata <= 32'h0000_0000;
         for (int g = 0; g < NGEN; g++) begin
            s_r.gen_shadow[g] <= `PWMDC_DUTY_RST;
            s_r.gen_active[g] <= `PWMDC_DUTY_RST;
            s_r.dead_time_value[g] <= `PWMDC_DT_RST;
            s_r.alternate_dead_time_value[g] <= `PWMDC_DT_RST;
            s_r.gen_ctrl[g] <= `PWMDC_CTRL_RST;
            s_r.cnt_rise[g] <= 11'h000;
            s_r.cnt_fall[g] <= 11'h000;
            s_r.fine[g] <= 3'h0;
         end
         s_r.cmp <= '0;
         s_r.hs <= '0;
         s_r.ls <= '0;
         s_r.dt_fine <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs taken straight from the state register
   assign avs_readdata = s_r.rdata;
   assign avs_waitrequest = s_r.wait_r;
   assign high_side_output = s_r.hs;
   assign low_side_output = s_r.ls;
   assign duty_fine_adj = s_r.fine;
   assign dead_time_fine_adj = s_r.dt_fine;

endmodule
`default_nettype wire

//--- testbench/pwmdc_top_properties.sv
// Concurrent checks on the bus handshake and the generator 0 pin pair
`default_nettype none
`include "pwmdc_regs.svh"
module pwmdc_top_properties #(
   parameter int NGEN = 4
) (
   input wire logic ref_clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic [NGEN*13-1:0] tb_count, // Time-base counts
   input wire logic primary_time_count_rollover, // Rollover pulse
   input wire logic [7:0] avs_address, // Address
   input wire logic avs_read, // Read
   input wire logic avs_write, // Write
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Lanes
   input wire logic [31:0] avs_readdata, // Read data
   input wire logic avs_waitrequest, // Stall
   input wire logic [NGEN-1:0] high_side_output, // High side
   input wire logic [NGEN-1:0] low_side_output, // Low side
   input wire logic [NGEN*3-1:0] duty_fine_adj, // Duty fine bits
   input wire logic [NGEN-1:0] dead_time_fine_adj // Dead-time fine bit
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] ctl_r; // Shadow of generator 0 control
   logic [11:0] dt_r; // Shadow of generator 0 dead time
   logic [3:0] quiet_r; // Cycles since last write, saturating
   logic ok;
   logic hi;
   logic lo;
   assign hi = high_side_output[0];
   assign lo = low_side_output[0];
   // Pins are judged only once pending dead-time counts from old settings have run out
   assign ok = quiet_r == 4'hF;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_r <= 4'h0;
         dt_r <= 12'h000;
         quiet_r <= 4'h0;
      end else begin
         quiet_r <= (avs_write && !avs_waitrequest) ? 4'h0 : quiet_r + {3'h0, !ok};
         if (avs_write && !avs_waitrequest && avs_address == `PWMDC_GEN_CTRL_OFS) begin
            ctl_r <= avs_writedata[3:0];
         end
         if (avs_write && !avs_waitrequest && avs_address == `PWMDC_DEAD_TIME_OFS) begin
            dt_r <= avs_writedata[11:0];
         end
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   a_wait_answer: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one stall cycle");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer lasted more than one cycle");
   a_no_overlap: assert property (ok && ctl_r == 4'h0 |-> !(hi && lo))
      else $error("both sides on under positive dead time");
   a_comp_off: assert property (ok && ctl_r == 4'h2 |-> lo == !hi)
      else $error("low side not the inverse with dead time off");
   a_indep_copy: assert property (ok && ctl_r == 4'hA |-> lo == hi)
      else $error("independent pins differ");
   a_dead_gap: assert property (
      ok && ctl_r == 4'h0 && dt_r[11:2] != 0 && $rose(hi) |-> !$past(lo))
      else $error("high side rose without a gap");
   a_neg_overlap: assert property (
      ok && ctl_r == 4'h1 && dt_r[11:2] != 0 && $rose(hi) |-> lo ##1 lo)
      else $error("no overlap under negative dead time");
   a_dt_fine: assert property (ok |-> dead_time_fine_adj[0] == dt_r[0])
      else $error("dead-time fine bit differs from register");
endmodule
bind pwmdc_top pwmdc_top_properties #(.NGEN(NGEN)) u_props (.ref_clk(ref_clk), .rst_n(rst_n),
   .tb_count(tb_count), .primary_time_count_rollover(primary_time_count_rollover), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .high_side_output(high_side_output),
   .low_side_output(low_side_output), .duty_fine_adj(duty_fine_adj),
   .dead_time_fine_adj(dead_time_fine_adj));
`default_nettype wire

//--- testbench/pwmdc_gate_model.sv
// Power stage model that counts cycles with both transistors on
`default_nettype none
module pwmdc_gate_model (
   input wire logic ref_clk, // Clock
   input wire logic clear, // Restart the count
   input wire logic gate_hi, // High-side drive
   input wire logic gate_lo, // Low-side drive
   output var int shoot_cycles // Cycles of cross conduction
);
   timeunit 1ns;
   timeprecision 100ps;
   // Cross conduction is only wanted under negative dead time, so it is measured, not refused
   always @(posedge ref_clk) begin
      if (clear) begin
         shoot_cycles <= 0;
      end else if (gate_hi && gate_lo) begin
         shoot_cycles <= shoot_cycles + 1;
      end
   end
endmodule
`default_nettype wire

//--- testbench/pwm_duty_compare_dead_time_bench.sv
// Self-checking bench of the PWM duty compare and dead-time block
`default_nettype none
`include "pwmdc_regs.svh"
module pwm_duty_compare_dead_time_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [11:0] DT = 12'h010;
   localparam logic [11:0] ADT = 12'h00C;
   logic ref_clk, rst_n, primary_time_count_rollover, avs_read, avs_write, avs_waitrequest, gclr;
   logic [51:0] tb_count;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable, high_side_output, low_side_output, dead_time_fine_adj;
   logic [11:0] duty_fine_adj;
   int shoot, n_errors = 0, comparisons = 0, cycles = 0;
   pwmdc_top #(.NGEN(4)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .tb_count(tb_count),
      .primary_time_count_rollover(primary_time_count_rollover), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .high_side_output(high_side_output), .low_side_output(low_side_output),
      .duty_fine_adj(duty_fine_adj), .dead_time_fine_adj(dead_time_fine_adj));
   pwmdc_gate_model u_gate (.ref_clk(ref_clk), .clear(gclr), .gate_hi(high_side_output[0]),
      .gate_lo(low_side_output[0]), .shoot_cycles(shoot));
   task automatic complete_run();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Bus cycles hold the request until the edge that samples waitrequest low
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      tick(1);
   endtask
   // Moves generator 0 count and records when each pin of the pair first changes;
   // one edge first lets a pin change launched by the last write settle before sampling,
   // and 30 cycles per level keep on and off times well over 3x dead time
   task automatic gap(input logic [12:0] c, output int th, output int tl);
      logic h0, l0;
      tick(1);
      h0 = high_side_output[0];
      l0 = low_side_output[0];
      th = -1;
      tl = -1;
      tb_count[12:0] <= c;
      for (int i = 0; i < 30; i++) begin
         @(posedge ref_clk);
         if (th < 0 && high_side_output[0] !== h0) th = i;
         if (tl < 0 && low_side_output[0] !== l0) tl = i;
      end
   endtask
   task automatic t_regs();
      logic [31:0] d;
      for (int g = 0; g < 4; g++) wr(`PWMDC_GEN_DUTY_OFS + 8'(4 * g), 32'hABC0 + 32'(g));
      for (int g = 0; g < 4; g++) begin
         rd(`PWMDC_GEN_DUTY_OFS + 8'(4 * g), d);
         chk("duty", d, 32'hABC0 + 32'(g));
      end
      wr(`PWMDC_MASTER_DUTY_OFS, 32'h1234_5678);
      rd(`PWMDC_MASTER_DUTY_OFS, d);
      chk("master", d, 32'h5678);
      avs_byteenable <= 4'h2;
      wr(`PWMDC_MASTER_DUTY_OFS, 32'h0000_AA00);
      avs_byteenable <= 4'hF;
      rd(`PWMDC_MASTER_DUTY_OFS, d);
      chk("master lane", d, 32'hAA78);
      wr(`PWMDC_DEAD_TIME_OFS, 32'hFFFF_FFFF);
      rd(`PWMDC_DEAD_TIME_OFS, d);
      chk("dead time", d, 32'h0FFF);
      wr(`PWMDC_DEAD_TIME_OFS, 32'h0);
      rd(8'h60, d);
      chk("unmapped", d, 32'h0);
   endtask
   // Mid values stay in the legal duty range; the two ends are the forced cases
   task automatic t_cmp();
      logic [15:0] dv [5] = '{16'h0000, 16'hFFFF, 16'h0105, 16'h0105, 16'h0008};
      logic [12:0] cv [5] = '{13'h0000, 13'h1FFF, 13'h0020, 13'h0021, 13'h0000};
      logic ev [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      wr(`PWMDC_GEN_CTRL_OFS, 32'h2);
      for (int i = 0; i < 5; i++) begin
         wr(`PWMDC_GEN_DUTY_OFS, {16'h0, dv[i]});
         tb_count[12:0] <= cv[i];
         tick(16);
         chk("high", high_side_output[0], ev[i]);
         chk("low", low_side_output[0], !ev[i]);
         chk("fine", duty_fine_adj[2:0], dv[i][2:0]);
      end
   endtask
   // Generators 0 and 1 share the master duty; 2 and 3 keep their own
   task automatic t_master();
      logic [31:0] d;
      wr(`PWMDC_MASTER_DUTY_OFS, 32'h0200);
      wr(`PWMDC_GEN_DUTY_OFS, 32'h0);
      wr(`PWMDC_GEN_CTRL_OFS, 32'h6);
      wr(`PWMDC_GEN_CTRL_OFS + 8'h04, 32'h6);
      tb_count[25:0] <= {2{13'h0040}};
      tick(16);
      chk("master high", high_side_output[0], 1'b1);
      chk("master high 1", high_side_output[1], 1'b1);
      tb_count[25:0] <= {2{13'h0041}};
      tick(16);
      chk("master low", high_side_output[0], 1'b0);
      chk("master low 1", high_side_output[1], 1'b0);
      rd(`PWMDC_STATUS_OFS, d);
      chk("status", d, 32'h0003_0C0C);
   endtask
   task automatic t_indep();
      int th0, tl0, th, tl;
      wr(`PWMDC_GEN_DUTY_OFS, 32'h0200);
      wr(`PWMDC_GEN_CTRL_OFS, 32'hA);
      gap(13'h0000, th0, tl0);
      chk("copy", tl0, th0);
      gap(13'h0041, th, tl);
      wr(`PWMDC_DEAD_TIME_OFS, {20'h0, DT});
      wr(`PWMDC_GEN_CTRL_OFS, 32'h8);
      gap(13'h0000, th, tl);
      chk("indep delay", th - th0, DT[11:1]);
      chk("indep copy", tl, th);
   endtask
   task automatic t_hold();
      logic [31:0] d;
      wr(`PWMDC_GEN_CTRL_OFS, 32'h2);
      wr(`PWMDC_GEN_DUTY_OFS, 32'h0200);
      wr(`PWMDC_GLOBAL_CTRL_OFS, 32'h1);
      rd(`PWMDC_GLOBAL_CTRL_OFS, d);
      chk("hold bit", d, 32'h1);
      wr(`PWMDC_GEN_DUTY_OFS, 32'h0205);
      tick(4);
      chk("held fine", duty_fine_adj[2:0], 3'h0);
      primary_time_count_rollover <= 1'b1;
      tick(1);
      primary_time_count_rollover <= 1'b0;
      tick(3);
      chk("rollover fine", duty_fine_adj[2:0], 3'h5);
      wr(`PWMDC_GLOBAL_CTRL_OFS, 32'h0);
   endtask
   task automatic t_dead();
      int th, tl;
      wr(`PWMDC_GEN_DUTY_OFS, 32'h0200);
      wr(`PWMDC_DEAD_TIME_OFS, {20'h0, DT});
      wr(`PWMDC_ALT_DEAD_TIME_OFS, {20'h0, ADT});
      wr(`PWMDC_GEN_CTRL_OFS, 32'h0);
      gap(13'h0041, th, tl);
      gclr <= 1'b1;
      tick(1);
      gclr <= 1'b0;
      gap(13'h0000, th, tl);
      chk("rise lag", th - tl, DT[11:1]);
      gap(13'h0041, th, tl);
      chk("fall lag", tl - th, DT[11:1]);
      chk("no overlap", shoot, 0);
      wr(`PWMDC_GEN_CTRL_OFS, 32'h3);
      gap(13'h0000, th, tl);
      chk("dual rise", th - tl, DT[11:1]);
      gap(13'h0041, th, tl);
      chk("dual fall", tl - th, ADT[11:1]);
      wr(`PWMDC_GEN_CTRL_OFS, 32'h1);
      gclr <= 1'b1;
      tick(16);
      gclr <= 1'b0;
      gap(13'h0000, th, tl);
      chk("neg rise", tl - th, DT[11:1]);
      gap(13'h0041, th, tl);
      chk("neg fall", th - tl, DT[11:1]);
      chk("overlap", shoot, 2 * DT[11:1]);
      wr(`PWMDC_DEAD_TIME_OFS, 32'h011);
      tick(3);
      chk("dead fine", dead_time_fine_adj[0], 1'b1);
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // A hang is cut short well beyond the several hundred cycles the run needs
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      rst_n <= 1'b0;
      tb_count <= '0;
      primary_time_count_rollover <= 1'b0;
      avs_address <= 8'h00;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= 32'h0;
      avs_byteenable <= 4'hF;
      gclr <= 1'b0;
      tick(4);
      rst_n <= 1'b1;
      tick(2);
      t_regs();
      t_cmp();
      t_master();
      t_indep();
      t_hold();
      t_dead();
      complete_run();
   end
endmodule
`default_nettype wire
